// ### hdl/shunt_amp_mode_control.v
// Top of the shunt amplifier mode control block
//
// Chosen here: the register offsets and strobed register access.
`include "shunt_amp_consts.vh"
module shunt_amp_mode_control #(
   parameter TRIM_CYCLES = `TRIM_CYC
) (
   input wire sys_clk,
   input wire rst,
   input wire [`ADDR_W-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire cal_pin,
   input wire [1:0] mode_level_pin,
   input wire [1:0] gain_level_pin,
   input wire [2:0] gate_current_level_pin,
   input wire [2:0] drain_source_level_pin,
   input wire [2:0] ls_on,
   input wire [2:0] drive_done,
   input wire fault_active,
   input wire serial_out_low,
   output wire [5:0] amp_gain,
   output wire [2:0] inputs_short,
   output wire [2:0] load_disc,
   output wire [2:0] sw_node_conn,
   output wire [2:0] amp_enable,
   output reg ref_div_bypass,
   output reg ls_mon_ref_neg,
   output reg [1:0] hw_mode,
   output reg [2:0] hw_drive_strength,
   output reg [2:0] hw_vds_threshold,
   output wire fault_indicator_n_out,
   output wire fault_indicator_n_oe,
   output wire serial_data_out,
   output wire serial_data_oe
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [`CTRL_W-1:0] ctrl_reg;
   reg [5:0] gain_reg;
   reg [2:0] per_channel_cal_request_reg;
   wire [2:0] trim_busy;
   wire [2:0] trim_done;

   // ----------------------------------------
   // Pin synchronisers, change on 2nd/3rd agree
   // ----------------------------------------
   localparam PW = 11;
   wire [PW-1:0] pin_raw;
   reg [PW-1:0] s1_reg;
   reg [PW-1:0] s2_reg;
   reg [PW-1:0] s3_reg;
   reg [PW-1:0] pin_reg;
   assign pin_raw = {cal_pin, mode_level_pin, gain_level_pin,
                     gate_current_level_pin, drain_source_level_pin};

   integer i;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= {PW{1'b0}};
         s2_reg <= {PW{1'b0}};
         s3_reg <= {PW{1'b0}};
         pin_reg <= {PW{1'b0}};
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (i = 0; i < PW; i = i + 1) begin
            if (s2_reg[i] == s3_reg[i]) begin
               pin_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   wire cal_pin_s;
   wire [1:0] mode_s;
   wire [1:0] gain_s;
   wire [2:0] idrv_s;
   wire [2:0] vds_s;
   assign {cal_pin_s, mode_s, gain_s, idrv_s, vds_s} = pin_reg;

   wire hw_if;
   assign hw_if = ctrl_reg[`CTRL_HWIF];

   // ----------------------------------------
   // Level pin decode for hardware variants
   // ----------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hw_mode <= 2'h0;
         hw_drive_strength <= 3'h0;
         hw_vds_threshold <= 3'h0;
      end else if (hw_if) begin
         hw_mode <= mode_s;
         hw_drive_strength <= (idrv_s == 3'h7) ? 3'h6 : idrv_s;
         hw_vds_threshold <= (vds_s == 3'h7) ? 3'h6 : vds_s;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `CTRL_RST;
         gain_reg <= `GAIN_RST;
         per_channel_cal_request_reg <= 3'h0;
      end else if (wr) begin
         case (addr)
            `OFF_CTRL: ctrl_reg <= wdata[`CTRL_W-1:0];
            `OFF_GAIN: gain_reg <= wdata[5:0];
            `OFF_CAL: per_channel_cal_request_reg <= wdata[2:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // ----------------------------------------
   // Mode outputs
   // ----------------------------------------
   wire fet_mode;
   assign fet_mode = ctrl_reg[`CTRL_FET] & ~hw_if;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ref_div_bypass <= 1'b0;
         ls_mon_ref_neg <= 1'b0;
      end else begin
         ref_div_bypass <= ctrl_reg[`CTRL_BYPASS] & ~hw_if;
         if (fet_mode) begin
            ls_mon_ref_neg <= 1'b1;
         end else begin
            ls_mon_ref_neg <= ctrl_reg[`CTRL_LSREF] & ~hw_if;
         end
      end
   end

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : ch
         wire req;
         wire [1:0] cfg;
         assign req = hw_if ? cal_pin_s : per_channel_cal_request_reg[g];
         assign cfg = hw_if ? gain_s : gain_reg[2*g+1:2*g];
         amp_channel #(.TRIM_CYCLES(TRIM_CYCLES)) u_ch (
            .sys_clk(sys_clk),
            .rst(rst),
            .cal_req(req),
            .cfg_gain(cfg),
            .fet_mode(fet_mode),
            .ls_on(ls_on[g]),
            .drive_done(drive_done[g]),
            .amp_gain(amp_gain[2*g+1:2*g]),
            .inputs_short(inputs_short[g]),
            .load_disc(load_disc[g]),
            .sw_node_conn(sw_node_conn[g]),
            .amp_enable(amp_enable[g]),
            .trim_busy(trim_busy[g]),
            .trim_done(trim_done[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Open-drain outputs
   // ----------------------------------------
   assign fault_indicator_n_out = 1'b0;
   assign fault_indicator_n_oe = fault_active;
   assign serial_data_out = 1'b0;
   assign serial_data_oe = serial_out_low;

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         case (addr)
            `OFF_CTRL: rdata <= {28'h0000000, ctrl_reg};
            `OFF_GAIN: rdata <= {26'h0000000, gain_reg};
            `OFF_CAL: rdata <= {29'h00000000, per_channel_cal_request_reg};
            `OFF_STATUS: rdata <= {26'h0000000, trim_done, trim_busy};
            `OFF_LEVELS: rdata <= {21'h000000, pin_reg};
            `OFF_ID: rdata <= `ID_VALUE;
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end
endmodule

// ### hdl/shunt_amp_consts.vh
// Constants for the shunt amplifier mode control block
`ifndef SHUNT_AMP_CONSTS_VH
`define SHUNT_AMP_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_W 4
`define OFF_CTRL 4'h0
`define OFF_GAIN 4'h1
`define OFF_CAL 4'h2
`define OFF_STATUS 4'h3
`define OFF_LEVELS 4'h4
`define OFF_ID 4'h5

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_BYPASS 0
`define CTRL_FET 1
`define CTRL_LSREF 2
`define CTRL_HWIF 3
`define CTRL_W 4
`define CTRL_RST 4'h0

// ----------------------------------------
// Gain codes
// ----------------------------------------
`define GAIN_5 2'h0
`define GAIN_10 2'h1
`define GAIN_20 2'h2
`define GAIN_40 2'h3
`define GAIN_RST 6'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 250
`define TRIM_US 100
`define TRIM_CYC (`TRIM_US * `CLK_MHZ)
`define CNT_W 15
`define ID_VALUE 32'h0000A5C3 // Arbitrary value

`endif

// ### hdl/amp_channel.v
// One amplifier channel: calibration sequencer and input routing
`include "shunt_amp_consts.vh"
module amp_channel #(
   parameter TRIM_CYCLES = `TRIM_CYC
) (
   input wire sys_clk,
   input wire rst,
   input wire cal_req,
   input wire [1:0] cfg_gain,
   input wire fet_mode,
   input wire ls_on,
   input wire drive_done,
   output reg [1:0] amp_gain,
   output reg inputs_short,
   output reg load_disc,
   output reg sw_node_conn,
   output reg amp_enable,
   output reg trim_busy,
   output reg trim_done
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam S_IDLE = 3'b001;
   localparam S_TRIM = 3'b010;
   localparam S_HOLD = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [`CNT_W-1:0] cnt_reg;
   reg [`CNT_W-1:0] cnt_next;
   reg fet_on_reg;
   reg fet_on_next;

   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         S_IDLE: begin
            cnt_next = {`CNT_W{1'b0}};
            if (cal_req) begin
               state_next = S_TRIM;
            end
         end
         S_TRIM: begin
            cnt_next = cnt_reg + 1'b1;
            if (!cal_req) begin
               state_next = S_IDLE;
            end else if (cnt_reg == TRIM_CYCLES - 1) begin
               state_next = S_HOLD;
            end
         end
         S_HOLD: begin
            if (!cal_req) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Transistor-drop gating: on at window end, off when low side off
   always @* begin
      fet_on_next = fet_on_reg;
      if (!fet_mode || !ls_on) begin
         fet_on_next = 1'b0;
      end else if (drive_done) begin
         fet_on_next = 1'b1;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         cnt_reg <= {`CNT_W{1'b0}};
         fet_on_reg <= 1'b0;
         amp_gain <= `GAIN_5;
         inputs_short <= 1'b0;
         load_disc <= 1'b0;
         sw_node_conn <= 1'b0;
         amp_enable <= 1'b0;
         trim_busy <= 1'b0;
         trim_done <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         fet_on_reg <= fet_on_next;
         if (state_next != S_IDLE) begin
            amp_gain <= `GAIN_40;
            inputs_short <= 1'b1;
            load_disc <= 1'b1;
            sw_node_conn <= 1'b0;
            amp_enable <= 1'b1;
         end else begin
            amp_gain <= cfg_gain;
            load_disc <= 1'b0;
            inputs_short <= fet_mode & ~fet_on_next;
            sw_node_conn <= fet_mode & fet_on_next;
            amp_enable <= ~fet_mode | fet_on_next;
         end
         trim_busy <= (state_next == S_TRIM);
         trim_done <= (state_next == S_HOLD);
      end
   end
endmodule

// ### verif/shunt_amp_checker.sv
// Assertion checker for the shunt amplifier mode control block
module shunt_amp_checker #(parameter TRIM_CYCLES = 20) (
   input logic sys_clk, rst, wr, fault_active, serial_out_low,
   input logic [3:0] addr,
   input logic [31:0] wdata,
   input logic [2:0] ls_on, inputs_short, load_disc,
   input logic [2:0] sw_node_conn, amp_enable,
   input logic [5:0] amp_gain,
   input logic ref_div_bypass, ls_mon_ref_neg, fault_indicator_n_out,
   input logic fault_indicator_n_oe, serial_data_out, serial_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ctrl_q;
   logic [5:0] gain_q;
   logic cal_q;
   logic [1:0] age;
   wire ok = age[1];
   wire sw = ok && !ctrl_q[3];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 4'h0;
         gain_q <= 6'h00;
         cal_q <= 1'h0;
         age <= 2'h0;
      end else begin
         age <= wr ? 2'h0 : age + {1'h0, !ok};
         if (wr && addr == 4'h0) ctrl_q <= wdata[3:0];
         if (wr && addr == 4'h1) gain_q <= wdata[5:0];
         if (wr && addr == 4'h2) cal_q <= wdata[0];
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   AST_GAIN: assert property (sw && load_disc == 3'h0
      |-> amp_gain == gain_q) else $error("gain off setting");
   AST_CAL: assert property (load_disc[0]
      |-> inputs_short[0] && amp_gain[1:0] == 2'h3) else $error("cal state");
   AST_HOLD: assert property (sw && cal_q |-> load_disc[0])
      else $error("cal dropped early");
   AST_BYPASS: assert property (ok
      |-> ref_div_bypass == (ctrl_q[0] && !ctrl_q[3])) else $error("bypass");
   AST_FETREF: assert property (sw && ctrl_q[1] |-> ls_mon_ref_neg)
      else $error("fet reference");
   AST_LSREF: assert property (sw && !ctrl_q[1]
      |-> ls_mon_ref_neg == ctrl_q[2]) else $error("reference select");
   AST_OD: assert property (!fault_indicator_n_out && !serial_data_out
      && fault_indicator_n_oe == fault_active
      && serial_data_oe == serial_out_low) else $error("open drain");
   AST_FETSHORT: assert property (sw && ctrl_q[1] && !load_disc[0]
      && $fell(ls_on[0]) |=> inputs_short[0]) else $error("no input short");
   AST_FETCONN: assert property (sw_node_conn[0]
      |-> amp_enable[0] && !inputs_short[0]) else $error("switch node route");
   AST_FETWAIT: assert property (sw && ctrl_q[1] && !load_disc[0]
      && !sw_node_conn[0] |-> !amp_enable[0]) else $error("early enable");
   cover property (cal_q ##1 !cal_q);
   cover property (sw && ctrl_q[1] && $fell(ls_on[0]));
   cover property (fault_indicator_n_oe && serial_data_oe);
endmodule
bind shunt_amp_mode_control shunt_amp_checker
   #(.TRIM_CYCLES(TRIM_CYCLES)) watch (.sys_clk, .rst, .wr, .fault_active,
   .serial_out_low, .addr, .wdata, .ls_on, .inputs_short, .load_disc,
   .amp_gain, .ref_div_bypass, .ls_mon_ref_neg, .fault_indicator_n_out,
   .fault_indicator_n_oe, .serial_data_out, .serial_data_oe, .sw_node_conn,
   .amp_enable);

// ### verif/cal_controller.sv
// Motor controller model driving the calibration pin
module cal_controller #(parameter HOLD = 40) (
   input logic sys_clk, rst, start,
   input logic [2:0] ls_on,
   output logic cal_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cal_pin <= 1'h0;
         cnt <= 8'h00;
      end else if (start && ls_on == 3'h0) begin
         cal_pin <= 1'h1;
         cnt <= HOLD[7:0];
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else begin
         cal_pin <= 1'h0;
      end
   end
endmodule

// ### verif/tb_shunt_amp_mode_control.sv
// Testbench for the shunt amplifier mode control block
module tb_shunt_amp_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, start = 1'h0;
   logic fault_active = 1'h0, serial_out_low = 1'h0, cal_pin;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] mode_level_pin = 2'h0, gain_level_pin = 2'h0, hw_mode;
   logic [2:0] gate_current_level_pin = 3'h0, drain_source_level_pin = 3'h0;
   logic [2:0] ls_on = 3'h0, drive_done = 3'h0, inputs_short, load_disc;
   logic [2:0] sw_node_conn, amp_enable, hw_drive_strength, hw_vds_threshold;
   logic [5:0] amp_gain;
   logic ref_div_bypass, ls_mon_ref_neg, fault_indicator_n_out;
   logic fault_indicator_n_oe, serial_data_out, serial_data_oe;
   integer errors = 0, comparisons = 0;
   wire [3:0] od = {fault_indicator_n_out, fault_indicator_n_oe,
      serial_data_out, serial_data_oe};
   always #2 sys_clk = ~sys_clk;
   shunt_amp_mode_control #(.TRIM_CYCLES(20)) DUT (.sys_clk, .rst, .addr,
      .wdata, .wr, .rd, .rdata, .cal_pin, .mode_level_pin, .gain_level_pin,
      .gate_current_level_pin, .drain_source_level_pin, .ls_on, .drive_done,
      .fault_active, .serial_out_low, .amp_gain, .inputs_short, .load_disc,
      .sw_node_conn, .amp_enable, .ref_div_bypass, .ls_mon_ref_neg, .hw_mode,
      .hw_drive_strength, .hw_vds_threshold, .fault_indicator_n_out,
      .fault_indicator_n_oe, .serial_data_out, .serial_data_oe);
   cal_controller ctl (.sys_clk, .rst, .start, .ls_on, .cal_pin);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge sys_clk);
      wr <= 1'h0;
      rd <= 1'h0;
      #1;
   endtask
   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'h0;
      acc(1'h0, 4'h9, 32'h0);
      chk(rdata, 32'h0);
      for (int g = 0; g < 4; g++) begin
         acc(1'h1, 4'h1, {26'h0, g[1:0], g[1:0], g[1:0]});
         cyc(3);
         chk(amp_gain, {3{g[1:0]}});
      end
      acc(1'h0, 4'h1, 32'h0);
      chk(rdata, 32'h3F);
      acc(1'h1, 4'h1, 32'h21);
      acc(1'h1, 4'h2, 32'h1);
      cyc(2);
      chk({load_disc, inputs_short, amp_gain}, 12'h263);
      cyc(17);
      acc(1'h0, 4'h3, 32'h0);
      chk(rdata & 32'h3F, 32'h01);
      acc(1'h0, 4'h3, 32'h0);
      chk(rdata & 32'h3F, 32'h08);
      chk({load_disc, amp_gain}, 9'h063);
      acc(1'h1, 4'h2, 32'h0);
      cyc(2);
      chk({load_disc, inputs_short, amp_gain}, 12'h021);
      acc(1'h1, 4'h2, 32'h4);
      cyc(3);
      acc(1'h1, 4'h2, 32'h0);
      cyc(2);
      chk({load_disc, amp_gain}, 9'h021);
      acc(1'h0, 4'h3, 32'h0);
      chk(rdata & 32'h4, 32'h0);
      for (int c = 0; c < 8; c++) begin
         acc(1'h1, 4'h0, c[31:0]);
         cyc(2);
         chk({ref_div_bypass, ls_mon_ref_neg}, {c[0], |c[2:1]});
      end
      acc(1'h1, 4'h0, 32'h2);
      cyc(2);
      chk({amp_enable, inputs_short}, 6'h07);
      @(posedge sys_clk);
      ls_on <= 3'h7;
      drive_done <= 3'h7;
      @(posedge sys_clk);
      drive_done <= 3'h0;
      cyc(3);
      chk({sw_node_conn, amp_enable, inputs_short}, 9'h1F8);
      @(posedge sys_clk);
      ls_on <= 3'h0;
      fault_active <= 1'h1;
      cyc(1);
      chk(inputs_short, 3'h7);
      chk(od, 4'h4);
      acc(1'h1, 4'h0, 32'h8);
      @(posedge sys_clk);
      serial_out_low <= 1'h1;
      mode_level_pin <= 2'h2;
      gain_level_pin <= 2'h1;
      gate_current_level_pin <= 3'h7;
      drain_source_level_pin <= 3'h5;
      cyc(8);
      chk({hw_mode, hw_drive_strength, hw_vds_threshold}, 8'hB5);
      chk(od, 4'h5);
      @(posedge sys_clk);
      start <= 1'h1;
      @(posedge sys_clk);
      start <= 1'h0;
      cyc(8);
      chk(load_disc, 3'h7);
      cyc(45);
      chk(load_disc, 3'h0);
      close_out;
   end
   initial begin
      #20000;
      errors++;
      close_out;
   end
endmodule
